// ---- ctl_model.sv ----
// controller dedicated output model driving the decoder pins
`timescale 1ns/1ps
module ctl_model (
  // clock
  input wire logic hclk,
  // commanded controller state
  input wire lamp_pkg::flags_t f_req,
  input wire logic [8:0] b_req,
  // pins toward the decoder
  output lamp_pkg::flags_t ctl_flags,
  output logic [lamp_pkg::OUT_W-1:0] ctl_out_bits
);
  import lamp_pkg::*;
  // pins change just after an edge, unrelated to the bus
  always @(posedge hclk)
  begin
    ctl_flags <= f_req;
    ctl_out_bits <= {7'h00, b_req};
  end
endmodule : ctl_model

// ---- lamp_chk.sv ----
// concurrent checks on the status lamp decoder ports
`timescale 1ns/1ps
module lamp_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // pins and lamp
  input wire lamp_pkg::flags_t ctl_flags,
  input wire lamp_pkg::lamp_t lamp
);
  import lamp_pkg::*;
  logic no_err;
  assign no_err = !ctl_flags.low_error_flag && !ctl_flags.high_error_flag;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // a level held long enough to cross sync, decode and output
  sequence s_held(b);
    b [*6];
  endsequence
  a_red_only: assert property (
    s_held(ctl_flags.low_error_flag) |-> (lamp & 6'h1f) == 6'h00)
    else $error("lamp not red alone under low error");
  a_warn_yellow: assert property (
    s_held(no_err && ctl_flags.warning_error_flag) |-> (lamp & 6'h2f) == 6'h00)
    else $error("lamp not yellow alone under warning");
  a_down_lblue: assert property (
    s_held(no_err && !ctl_flags.warning_error_flag && !ctl_flags.controller_up_flag)
    |-> (lamp & 6'h37) == 6'h00)
    else $error("lamp not light blue alone while controller down");
  a_one_lamp: assert property ($onehot0(lamp))
    else $error("more than one lamp colour lit");
  a_reset_dark: assert property ($rose(hresetn) |-> lamp == 6'h00)
    else $error("lamp lit right after reset");
  a_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("bus wait state inserted");
  a_idle_rdata: assert property (!(hsel && htrans[1] && hready) |=> hrdata == 32'h0)
    else $error("read data not zero without a transfer");
endmodule : lamp_chk

// ---- lamp_pkg.sv ----
// constants, types and register map of the status lamp decoder
package lamp_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INPUTS_OFS = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_FLASH_BIT = 3;
  localparam int ST_PHASE_BIT = 4;
  // ----------------------------------------
  // default bit positions in the dedicated output word
  // ----------------------------------------
  localparam int RUN_POS = 0;
  localparam int SERVO_POS = 1;
  localparam int HIGH_POS = 6;
  localparam int STD_POS = 7;
  localparam int LOW_POS = 8;
  localparam int OUT_W = 16;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 4;
  localparam int FLASH_HALF_NS = 500000000;
  localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    C_OFF = 3'b000,
    C_RED = 3'b001,
    C_YELLOW = 3'b010,
    C_LBLUE = 3'b011,
    C_WHITE = 3'b100,
    C_GREEN = 3'b101,
    C_BLUE = 3'b110
  } colour_t;
  typedef struct packed {
    logic low_error_flag;
    logic high_error_flag;
    logic warning_error_flag;
    logic controller_up_flag;
    logic hand_guiding_flag;
    logic safety_ok_flag;
  } flags_t;
  typedef struct packed {
    colour_t colour;
    logic flash;
  } sel_t;
  typedef struct packed {
    logic red;
    logic yellow;
    logic light_blue;
    logic white;
    logic green;
    logic blue;
  } lamp_t;
endpackage : lamp_pkg

// ---- status_lamp_priority_decoder.sv ----
// status lamp priority decoder with ahb-lite register slave
//
// Operation
// R1: first matching colour wins, fixed priority
// R2: low error gives steady red
// R3: high error gives flashing red
// R4: warning with low or standard gives steady yellow
// R5: warning with high speed gives flashing yellow
// R6: warning with no speed bit flashes yellow
// R7: controller up, servo off: steady light blue
// R8: controller not up: flashing light blue
// R9: high speed and running: flashing white
// R10: low speed and running: steady green
// R11: low speed and hand guiding: steady green
// R12: standard, running or guiding: flashing green
// R13: low/standard, idle, no guiding: steady blue
// R14: high speed, idle, no guiding: flashing blue
// R15: under warning, unsafe or servo off forces flashing yellow
// R16: one shared divider sets the flash phase
// R17: no match or reset drives lamp off
`timescale 1ns/1ps
module status_lamp_priority_decoder #(
  parameter int FLASH_HALF = lamp_pkg::FLASH_HALF_CYC,
  parameter int RUN_BIT = lamp_pkg::RUN_POS,
  parameter int SERVO_BIT = lamp_pkg::SERVO_POS,
  parameter int HIGH_BIT = lamp_pkg::HIGH_POS,
  parameter int STD_BIT = lamp_pkg::STD_POS,
  parameter int LOW_BIT = lamp_pkg::LOW_POS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // controller dedicated outputs (asynchronous pins)
  input wire lamp_pkg::flags_t ctl_flags,
  input wire logic [lamp_pkg::OUT_W-1:0] ctl_out_bits,
  // indicator lamp
  output lamp_pkg::lamp_t lamp
);
  import lamp_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (FLASH_HALF < 1 || FLASH_HALF > 32'h7fff_ffff)
    begin : g_bad_flash
      $error("flash half period out of range");
    end
    if (RUN_BIT >= OUT_W || SERVO_BIT >= OUT_W || HIGH_BIT >= OUT_W ||
        STD_BIT >= OUT_W || LOW_BIT >= OUT_W)
    begin : g_bad_pos
      $error("bit position beyond dedicated output word");
    end
    if (RUN_BIT < 0 || SERVO_BIT < 0 || HIGH_BIT < 0 || STD_BIT < 0 || LOW_BIT < 0)
    begin : g_neg_pos
      $error("bit position below zero");
    end
    // shared speed bits would let two colour rows match the same input
    if (HIGH_BIT == STD_BIT || HIGH_BIT == LOW_BIT || STD_BIT == LOW_BIT)
    begin : g_same_speed
      $error("speed mode bits share a position");
    end
    if (RUN_BIT == SERVO_BIT)
    begin : g_same_state
      $error("run and servo bits share a position");
    end
    // the colour code sits below the flash bit in the status word
    if (ST_FLASH_BIT < $bits(colour_t) || ST_PHASE_BIT == ST_FLASH_BIT ||
        ST_PHASE_BIT > 31 || ST_FLASH_BIT > 31 || ST_PHASE_BIT < $bits(colour_t))
    begin : g_bad_status
      $error("status field positions overlap");
    end
    if ($bits(flags_t) + OUT_W > 32)
    begin : g_bad_inputs
      $error("inputs word wider than the bus");
    end
    if (CTRL_EN_BIT < 0 || CTRL_EN_BIT > 31)
    begin : g_bad_en
      $error("enable bit beyond the control word");
    end
    if (CTRL_OFS[1:0] != 2'b00 || STATUS_OFS[1:0] != 2'b00 || INPUTS_OFS[1:0] != 2'b00)
    begin : g_bad_ofs
      $error("register offsets not word aligned");
    end
  endgenerate

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // decode reads only the second stage, never a possibly metastable first
  flags_t flags_m_r;
  flags_t flags_r;
  logic [OUT_W-1:0] bits_m_r;
  logic [OUT_W-1:0] bits_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags_m_r <= '0;
      flags_r <= '0;
      bits_m_r <= '0;
      bits_r <= '0;
    end
    else
    begin
      flags_m_r <= ctl_flags;
      flags_r <= flags_m_r;
      bits_m_r <= ctl_out_bits;
      bits_r <= bits_m_r;
    end
  end

  // speed bits packed as low, standard, high
  logic [2:0] speed_mode_bits;
  logic run_flag;
  logic servo_power_flag;
  assign speed_mode_bits = {bits_r[LOW_BIT], bits_r[STD_BIT], bits_r[HIGH_BIT]};
  assign run_flag = bits_r[RUN_BIT];
  assign servo_power_flag = bits_r[SERVO_BIT];

  // ----------------------------------------
  // priority decode
  // ----------------------------------------
  // rows are tried top-down; the first row that matches sets colour and form
  function automatic sel_t decode(input flags_t f, input logic [2:0] sp,
                                  input logic run, input logic srv);
    sel_t s;
    logic lo;
    logic st;
    logic hi;
    logic act;
    s = '{colour: C_OFF, flash: 1'b0};
    lo = sp[2];
    st = sp[1];
    hi = sp[0];
    act = run | f.hand_guiding_flag;
    if (f.low_error_flag) // R1
      s = '{colour: C_RED, flash: 1'b0}; // R2
    else if (f.high_error_flag)
      s = '{colour: C_RED, flash: 1'b1}; // R3
    else if (f.warning_error_flag)
    begin
      // steady only with low/standard speed and safe, powered servos
      s.colour = C_YELLOW;
      s.flash = !((lo | st) & f.safety_ok_flag & srv); // R4 R5 R6 R15
    end
    else if (f.controller_up_flag && !srv)
      s = '{colour: C_LBLUE, flash: 1'b0}; // R7
    else if (!f.controller_up_flag)
      s = '{colour: C_LBLUE, flash: 1'b1}; // R8
    else if (hi && run)
      s = '{colour: C_WHITE, flash: 1'b1}; // R9
    else if (lo && act)
      s = '{colour: C_GREEN, flash: 1'b0}; // R10 R11
    else if (st && act)
      s = '{colour: C_GREEN, flash: 1'b1}; // R12
    else if ((lo || st) && !act)
      s = '{colour: C_BLUE, flash: 1'b0}; // R13
    else if (hi && !act)
      s = '{colour: C_BLUE, flash: 1'b1}; // R14
    return s;
  endfunction : decode

  sel_t sel_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_r <= '{colour: C_OFF, flash: 1'b0};
    else
      sel_r <= decode(flags_r, speed_mode_bits, run_flag, servo_power_flag);
  end

  // ----------------------------------------
  // flash divider
  // ----------------------------------------
  logic [31:0] flash_cnt_r;
  logic phase_r;
  logic flash_tick;
  localparam logic [31:0] HALF_LAST = 32'(FLASH_HALF - 1);

  // one-cycle enable at the end of each half period; phase starts dark
  assign flash_tick = (flash_cnt_r >= HALF_LAST);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flash_cnt_r <= '0;
      phase_r <= 1'b0;
    end
    else if (flash_tick) // R16
    begin
      flash_cnt_r <= '0;
      phase_r <= !phase_r;
    end
    else
      flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
  end

  // ----------------------------------------
  // register select
  // ----------------------------------------
  // one-hot select shared by the read mux and the write strobe:
  // [0] control, [1] status, [2] inputs, none for an unmapped offset
  function automatic logic [2:0] reg_decode(input logic [7:0] a);
    logic [2:0] hit;
    hit = 3'b000;
    unique case (a)
      CTRL_OFS: hit = 3'b001;
      STATUS_OFS: hit = 3'b010;
      INPUTS_OFS: hit = 3'b100;
      default: hit = 3'b000;
    endcase
    return hit;
  endfunction : reg_decode

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic en_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic take;
  logic [31:0] rd_nxt;
  logic [31:0] status_word;
  logic [31:0] inputs_word;
  logic [2:0] rd_hit;
  logic [2:0] wr_hit;

  // zero wait states: every transfer is taken in its address phase
  // hsize and htrans[0] are not decoded; every transfer, burst or not, is served as a whole word
  assign take = hsel && hready && htrans[1];
  assign rd_hit = reg_decode(haddr[7:0]);
  assign wr_hit = reg_decode(wr_addr_r);

  // read words; fields sit at their package positions, spare bits read zero
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[2:0] = sel_r.colour;
    status_word[ST_FLASH_BIT] = sel_r.flash;
    status_word[ST_PHASE_BIT] = phase_r;
    inputs_word = 32'h0000_0000;
    inputs_word[OUT_W-1:0] = bits_r;
    inputs_word[OUT_W+$bits(flags_t)-1:OUT_W] = flags_r;
  end

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (take && !hwrite)
    begin
      if (rd_hit[0])
        rd_nxt = {31'h0, en_r};
      else if (rd_hit[1])
        rd_nxt = status_word;
      else if (rd_hit[2])
        rd_nxt = inputs_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hrdata <= rd_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      // a write lands at the end of its data phase, when hwdata stands
      wr_pend_r <= take && hwrite && (haddr[31:8] == 24'h0);
      wr_addr_r <= haddr[7:0];
    end
  end

  // control register: lamp enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_r <= CTRL_EN_RST;
    else if (wr_pend_r && wr_hit[0])
      en_r <= hwdata[CTRL_EN_BIT];
  end

  // ----------------------------------------
  // lamp drive
  // ----------------------------------------
  logic lit;
  lamp_t lamp_nxt;
  // flashing colours are dark while the shared phase is low
  assign lit = en_r && (!sel_r.flash || phase_r); // R16

  always_comb
  begin
    lamp_nxt = '0; // R17
    if (lit)
    begin
      unique case (sel_r.colour)
        C_RED: lamp_nxt.red = 1'b1;
        C_YELLOW: lamp_nxt.yellow = 1'b1;
        C_LBLUE: lamp_nxt.light_blue = 1'b1;
        C_WHITE: lamp_nxt.white = 1'b1;
        C_GREEN: lamp_nxt.green = 1'b1;
        C_BLUE: lamp_nxt.blue = 1'b1;
        default: lamp_nxt = '0;
      endcase
    end
  end

  // one more flop so the lamp pins come straight from a register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lamp <= '0; // R17
    else
      lamp <= lamp_nxt;
  end
endmodule : status_lamp_priority_decoder

// ---- status_lamp_priority_decoder_test.sv ----
// self-checking bench for the status lamp decoder
`timescale 1ns/1ps
module status_lamp_priority_decoder_test;
  import lamp_pkg::*;
  localparam int FH = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  wire logic hready = hreadyout;
  flags_t f_req = '0;
  flags_t ctl_flags;
  logic [8:0] b_req = 9'h000;
  logic [OUT_W-1:0] ctl_out_bits;
  lamp_t lamp;
  int n_fail = 0;
  int n_tests = 0;
  always #2 hclk = ~hclk;
  status_lamp_priority_decoder #(.FLASH_HALF(FH)) status_lamp_priority_decoder_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ctl_flags(ctl_flags),
    .ctl_out_bits(ctl_out_bits), .lamp(lamp));
  ctl_model ctl_model_i (.hclk(hclk), .f_req(f_req), .b_req(b_req),
    .ctl_flags(ctl_flags), .ctl_out_bits(ctl_out_bits));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task print_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task t_regs;
    logic [31:0] r;
    bus(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, {31'h0, CTRL_EN_RST});
    bus(1'b0, 8'h0c, 32'h0, r);
    chk(r, 32'h0);
    f_req <= 6'b000101;
    b_req <= 9'h103;
    repeat (6) @(posedge hclk);
    bus(1'b0, INPUTS_OFS, 32'h0, r);
    chk(r, {10'h000, 6'b000101, 16'h0103});
    bus(1'b1, CTRL_OFS, 32'h0, r);
    repeat (4) @(posedge hclk);
    chk({26'h0, lamp}, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h1, r);
    repeat (6) @(posedge hclk);
    chk({26'h0, lamp}, 32'h2);
    $display("t_regs done");
  endtask : t_regs
  task t_prio;
    logic [18:0] tc [15];
    logic [31:0] r;
    logic [5:0] e;
    int hit;
    tc = '{{6'b110000, 9'h000, C_RED, 1'b0}, {6'b010000, 9'h000, C_RED, 1'b1},
      {6'b001101, 9'h102, C_YELLOW, 1'b0}, {6'b001100, 9'h082, C_YELLOW, 1'b1},
      {6'b001101, 9'h042, C_YELLOW, 1'b1}, {6'b001101, 9'h002, C_YELLOW, 1'b1},
      {6'b000101, 9'h101, C_LBLUE, 1'b0}, {6'b000001, 9'h103, C_LBLUE, 1'b1},
      {6'b000101, 9'h043, C_WHITE, 1'b1}, {6'b000101, 9'h103, C_GREEN, 1'b0},
      {6'b000111, 9'h102, C_GREEN, 1'b0}, {6'b000111, 9'h082, C_GREEN, 1'b1},
      {6'b000101, 9'h082, C_BLUE, 1'b0}, {6'b000101, 9'h042, C_BLUE, 1'b1},
      {6'b000101, 9'h002, C_OFF, 1'b0}};
    foreach (tc[i])
    begin
      f_req <= tc[i][18:13];
      b_req <= tc[i][12:4];
      repeat (8) @(posedge hclk);
      bus(1'b0, STATUS_OFS, 32'h0, r);
      chk({28'h0, r[3:0]}, {28'h0, tc[i][0], tc[i][3:1]});
      e = (tc[i][3:1] == 3'b000) ? 6'h00 : 6'h20 >> (tc[i][3:1] - 3'd1);
      hit = 0;
      repeat (2 * FH + 2)
      begin
        @(posedge hclk);
        if (lamp === e)
          hit++;
        else
          chk({26'h0, lamp}, 32'h0);
      end
      chk(32'(tc[i][0] ? (hit > 2 && hit < 8) : hit == 2 * FH + 2), 32'h1);
    end
    $display("t_prio done");
  endtask : t_prio
  task t_reset;
    logic [31:0] r;
    f_req <= 6'b000101;
    b_req <= 9'h103;
    repeat (8) @(posedge hclk);
    chk({26'h0, lamp}, 32'h2);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({26'h0, lamp}, 32'h0);
    hresetn <= 1'b1;
    repeat (2)
    begin
      @(posedge hclk);
      chk({26'h0, lamp}, 32'h0);
    end
    bus(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, {31'h0, CTRL_EN_RST});
    repeat (8) @(posedge hclk);
    chk({26'h0, lamp}, 32'h2);
    $display("t_reset done");
  endtask : t_reset
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_prio();
    t_reset();
    print_verdict();
  end
  initial
  begin
    #20000;
    n_fail++;
    print_verdict();
  end
endmodule : status_lamp_priority_decoder_test
bind status_lamp_priority_decoder lamp_chk lamp_chk_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .ctl_flags(ctl_flags), .lamp(lamp));
